// [biphase_rx_regs.svh]
// Constants and register map of the biphase receiver clock selection block.
`ifndef BIPHASE_RX_REGS_SVH
`define BIPHASE_RX_REGS_SVH

`define CLK_HZ 50000000
`define FS_MIN_HZ 28000
`define FS_MAX_HZ 108000
`define WORD_BITS 24
`define CAPTURE_PERMIL 125
`define RESET_MIN_NS 100
`define LOCK_MAX_MS 100
`define LOCK_CYC ((`LOCK_MAX_MS * (`CLK_HZ / 1000)) - 1)
`define RESET_MIN_CYC ((`RESET_MIN_NS * (`CLK_HZ / 1000000) + 999) / 1000)

`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_RATIO 12'h008
`define REG_SAMPLE 12'h00c
`define CTRL_SEL_BIT 0
`define CTRL_AUTO_BIT 1
`define CTRL_RESET 32'h0000_0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define ERROR_IDLE 1'b1
`define BIT_CLK_POS 1
`define FRAME_CLK_POS 7
`define GAP_LIMIT 10'h3ff
`endif

// [biphase_rx_pkg.sv]
// Types shared by the biphase receiver clock selection block.
package biphase_rx_pkg;
    typedef enum logic [3:0] {
        LK_IDLE = 4'b0001,
        LK_SEEK = 4'b0010,
        LK_WAIT = 4'b0100,
        LK_LOCK = 4'b1000
    } lock_state_t;

    typedef struct packed {
        logic bit_clk;
        logic frame_clk;
        logic sys_clk;
    } clock_set_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
    } reg_write_t;
endpackage

// [clock_divider.sv]
// Divider that turns a source enable into system, bit and frame clock levels.
`timescale 1ns/1ps
`include "biphase_rx_regs.svh"
module clock_divider
    import biphase_rx_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic src_tick,
    input wire logic [1:0] ratio_sel,
    output clock_set_t clocks
);
    logic [10:0] cnt_ff;
    logic [1:0] sub_ff;
    logic [1:0] nxt_sub;
    logic sys_ff;

    // Each source tick is one system clock half period; the sub counter spaces
    // ratio steps so 64 fs bit clock stays fixed while the system ratio varies.
    always_comb
    begin
        nxt_sub = (sub_ff == ratio_sel) ? 2'h0 : sub_ff + 2'h1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sys_ff <= 1'b0;
            sub_ff <= 2'h0;
        end
        else if (src_tick)
        begin
            sys_ff <= ~sys_ff;
            sub_ff <= nxt_sub;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_ff <= 11'h000;
        else if (src_tick && sub_ff == ratio_sel)
            cnt_ff <= cnt_ff + 11'h001;
    end

    // Bit clock spans two system periods per ratio step; frame is 64 bit periods.
    assign clocks = '{
        bit_clk: cnt_ff[`BIT_CLK_POS],
        frame_clk: cnt_ff[`FRAME_CLK_POS],
        sys_clk: sys_ff
    };
endmodule

// [lock_detect.sv]
// Lock tracker that holds the error flag until the stream is locked.
`timescale 1ns/1ps
`include "biphase_rx_regs.svh"
module lock_detect
    import biphase_rx_pkg::*;
#(
    parameter logic [22:0] LOCK_CYCLES = 23'(`LOCK_CYC)
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stream_valid,
    input wire logic pll_locked,
    output logic error_flag,
    output lock_state_t state
);
    lock_state_t state_ff;
    lock_state_t nxt_state;
    logic [22:0] wait_ff;
    logic err_ff;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            LK_IDLE: nxt_state = LK_SEEK;
            LK_SEEK: if (stream_valid) nxt_state = LK_WAIT;
            LK_WAIT:
            begin
                if (!stream_valid)
                    nxt_state = LK_SEEK;
                else if (pll_locked)
                    nxt_state = LK_LOCK;
            end
            LK_LOCK: if (!stream_valid || !pll_locked) nxt_state = LK_SEEK;
            default: nxt_state = LK_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_ff <= LK_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Counts cycles spent locked on a live stream while the error is still raised.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !(stream_valid && pll_locked && err_ff))
            wait_ff <= 23'h000000;
        else
            wait_ff <= wait_ff + 23'h000001;
    end

    // Release comes on the same edge that the state enters LK_LOCK, far inside the allowed window.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            err_ff <= `ERROR_IDLE;
        else
            err_ff <= (nxt_state != LK_LOCK);
    end

    assign error_flag = err_ff;
    assign state = state_ff;

    a_err_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == LK_LOCK && pll_locked && stream_valid) |=> !err_ff)
        else $error("error flag not released after lock");
    a_err_unlock: assert property (@(posedge aclk) disable iff (!aresetn)
        !pll_locked |=> err_ff)
        else $error("error flag low while unlocked");
    a_wait_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        wait_ff <= LOCK_CYCLES)
        else $error("lock wait exceeded while locked");
endmodule

// [biphase_rx_clock.sv]
// Clock source selection, reset output levels and AXI4-Lite control for the receiver.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "biphase_rx_regs.svh"
module biphase_rx_clock
    import biphase_rx_pkg::*;
#(
    parameter logic [22:0] LOCK_CYCLES = 23'(`LOCK_CYC)
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic biphase_in,
    input wire logic pll_locked,
    input wire logic pll_tick,
    input wire logic osc_clock_in,
    input wire logic osc_tick,
    input wire logic clock_source_sel,
    input wire logic [1:0] pll_ratio_sel,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic system_clock_out,
    output logic bit_clock_out,
    output logic frame_clock_out,
    output logic error_flag,
    output logic block_start_flag,
    output logic clock_change_pulse,
    output logic channel_status_out,
    output logic emphasis_flag,
    output logic rate_code_out0,
    output logic rate_code_out1,
    output logic user_bit_out,
    output logic osc_drive_out
);
    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] r);
        reg_hit = (a[11:2] == r[11:2]);
    endfunction

    logic [31:0] ctrl_ff;
    logic [11:0] aw_addr_ff;
    logic aw_have_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic w_have_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [31:0] nxt_rdata;
    logic [1:0] nxt_rresp;
    logic [31:0] nxt_ctrl;
    logic err_int;
    lock_state_t lk_state;
    logic stream_valid;
    logic bi_q_ff;
    logic [9:0] edge_gap_ff;
    logic use_osc;
    logic use_osc_ff;
    logic src_tick;
    clock_set_t div_clocks;
    logic sys_out_ff;
    logic bit_out_ff;
    logic frame_out_ff;
    logic err_out_ff;
    logic chg_ff;
    logic frame_prev_ff;
    logic blk_ff;
    logic [31:0] sample_cnt_ff;

    // Stream presence: a biphase edge must appear well inside a slow frame.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bi_q_ff <= 1'b0;
            edge_gap_ff <= `GAP_LIMIT;
        end
        else
        begin
            bi_q_ff <= biphase_in;
            if (bi_q_ff != biphase_in)
                edge_gap_ff <= 10'h000;
            else if (edge_gap_ff != `GAP_LIMIT)
                edge_gap_ff <= edge_gap_ff + 10'h001;
        end
    end
    assign stream_valid = (edge_gap_ff != `GAP_LIMIT);

    lock_detect #(
        .LOCK_CYCLES(LOCK_CYCLES)
    ) u_lock_detect (
        .aclk(aclk),
        .aresetn(aresetn),
        .stream_valid(stream_valid),
        .pll_locked(pll_locked),
        .error_flag(err_int),
        .state(lk_state)
    );

    // Only the select pin, the control select bit and the optional auto bit steer the source; there is
    // no oscillator enable, so tying the pin to error gives automatic mode.
    assign use_osc = ctrl_ff[`CTRL_AUTO_BIT] ? err_int :
                     (clock_source_sel | ctrl_ff[`CTRL_SEL_BIT]);
    // A halted oscillator gives no ticks, so output clocks stop in error periods in automatic mode.
    assign src_tick = use_osc ? (osc_tick & osc_clock_in) : pll_tick;

    clock_divider u_clock_divider (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_tick(src_tick),
        .ratio_sel(pll_ratio_sel),
        .clocks(div_clocks)
    );

    // Switching is immediate; phase continuity is not kept across sources.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sys_out_ff <= 1'b0;
            bit_out_ff <= 1'b0;
            frame_out_ff <= 1'b0;
            err_out_ff <= `ERROR_IDLE;
        end
        else
        begin
            sys_out_ff <= div_clocks.sys_clk;
            bit_out_ff <= div_clocks.bit_clk;
            frame_out_ff <= div_clocks.frame_clk;
            err_out_ff <= err_int;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            use_osc_ff <= 1'b0;
            chg_ff <= 1'b0;
            frame_prev_ff <= 1'b0;
            blk_ff <= 1'b0;
            sample_cnt_ff <= 32'h0000_0000;
        end
        else
        begin
            use_osc_ff <= use_osc;
            chg_ff <= (use_osc_ff != use_osc);
            frame_prev_ff <= div_clocks.frame_clk;
            blk_ff <= div_clocks.frame_clk & ~frame_prev_ff & ~err_int;
            if (div_clocks.frame_clk & ~frame_prev_ff)
                sample_cnt_ff <= sample_cnt_ff + 32'h0000_0001;
        end
    end

    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        for (int i = 0; i < 4; i++)
            if (w_strb_ff[i])
                nxt_ctrl[i*8 +: 8] = w_data_ff[i*8 +: 8];
        nxt_ctrl[31:2] = 30'h0;
    end

    // Write channel: address and data may arrive in either order.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_addr_ff <= 12'h000;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
            ctrl_ff <= `CTRL_RESET;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (aw_have_ff && w_have_ff && !bvalid_ff)
            begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                if (reg_hit(aw_addr_ff, `REG_CTRL))
                begin
                    ctrl_ff <= nxt_ctrl;
                    bresp_ff <= `RESP_OKAY;
                end
                else
                    bresp_ff <= `RESP_SLVERR;
            end
            else if (bvalid_ff && s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    always_comb
    begin
        nxt_rresp = `RESP_OKAY;
        nxt_rdata = 32'h0000_0000;
        if (reg_hit(s_axi_araddr, `REG_CTRL))
            nxt_rdata = ctrl_ff;
        else if (reg_hit(s_axi_araddr, `REG_STATUS))
            nxt_rdata = {24'h0, lk_state, 1'b0, use_osc_ff, stream_valid, err_int};
        else if (reg_hit(s_axi_araddr, `REG_RATIO))
            nxt_rdata = {30'h0, pll_ratio_sel};
        else if (reg_hit(s_axi_araddr, `REG_SAMPLE))
            nxt_rdata = sample_cnt_ff;
        else
            nxt_rresp = `RESP_SLVERR;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
        else if (rvalid_ff && s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    assign s_axi_awready = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready = !w_have_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    assign system_clock_out = sys_out_ff;
    assign bit_clock_out = bit_out_ff;
    assign frame_clock_out = frame_out_ff;
    assign error_flag = err_out_ff;
    assign block_start_flag = blk_ff;
    assign clock_change_pulse = chg_ff;
    assign channel_status_out = 1'b0;
    assign emphasis_flag = 1'b0;
    assign rate_code_out0 = 1'b0;
    assign rate_code_out1 = 1'b0;
    assign user_bit_out = 1'b0;
    // Oscillator amplifier always runs, in reset too.
    assign osc_drive_out = ~osc_clock_in;

    a_reset_low: assert property (@(posedge aclk)
        !aresetn |=> !sys_out_ff && !bit_out_ff && !frame_out_ff && !blk_ff)
        else $error("clock outputs not low after reset");
    a_reset_err: assert property (@(posedge aclk)
        !aresetn |=> err_out_ff)
        else $error("error flag not high after reset");
    a_sel_osc: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctrl_ff[`CTRL_AUTO_BIT] && clock_source_sel) |-> src_tick == (osc_tick & osc_clock_in))
        else $error("select high did not pick oscillator");
    a_sel_pll: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_ff == 32'h0 && !clock_source_sel) |-> src_tick == pll_tick)
        else $error("select low did not pick pll");
    a_auto_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_ff[`CTRL_AUTO_BIT] && !err_int) |-> src_tick == pll_tick)
        else $error("auto mode not on pll without error");
    a_err_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(err_int) |=> err_out_ff)
        else $error("error output lags");
    // The output stage lags the divider by one flop, so stability is checked one cycle on.
    a_no_osc: assert property (@(posedge aclk) disable iff (!aresetn)
        (use_osc && !osc_clock_in) |=> ##1 $stable(sys_out_ff))
        else $error("clock toggled without oscillator");
    a_sw_change: assert property (@(posedge aclk) disable iff (!aresetn)
        (use_osc_ff != use_osc) |=> chg_ff)
        else $error("source change not flagged");
endmodule

// [biphase_tx_model.sv]
// Behavioural far side: biphase source, recovery PLL and oscillator.
`timescale 1ns/1ps
module biphase_tx_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stream_on,
    input wire logic lock_on,
    input wire logic pll_run,
    input wire logic osc_run,
    output logic biphase_in = 1'b0,
    output logic pll_locked = 1'b0,
    output logic pll_tick = 1'b0,
    output logic osc_tick = 1'b0,
    output logic osc_clock_in
);
    logic [1:0] cnt_ff = 2'h0;
    always @(posedge aclk)
    begin
        cnt_ff <= aresetn ? cnt_ff + 2'h1 : 2'h0;
        // A stopped stream holds its level, so the receiver sees no edges at all.
        if (stream_on && cnt_ff == 2'h3)
            biphase_in <= ~biphase_in;
        pll_locked <= aresetn && stream_on && lock_on;
        // The VCO keeps ticking while unlocked; its rate carries no meaning then.
        pll_tick <= pll_run;
        osc_tick <= osc_run && cnt_ff[0];
    end
    // An absent oscillator leaves its input tied to ground.
    assign osc_clock_in = osc_run;
endmodule

// [tb_biphase_rx_clock.sv]
// Self-checking bench for the receiver clock selection block.
`timescale 1ns/1ps
`include "biphase_rx_regs.svh"
module tb_biphase_rx_clock;
    import biphase_rx_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic stream_on = 1'b1, lock_on = 1'b0, pll_run = 1'b1, osc_run = 1'b1, tie_sel = 1'b0;
    logic biphase_in, pll_locked, pll_tick, osc_tick, osc_clock_in;
    logic clock_source_sel = 1'b0;
    logic [1:0] pll_ratio_sel = 2'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic system_clock_out, bit_clock_out, frame_clock_out, error_flag, block_start_flag;
    logic clock_change_pulse, channel_status_out, emphasis_flag, rate_code_out0;
    logic rate_code_out1, user_bit_out, osc_drive_out;
    int errors = 0;
    int checked = 0;

    biphase_rx_clock #(.LOCK_CYCLES(23'd100)) u_biphase_rx_clock (.*);
    biphase_tx_model u_biphase_tx_model (.*);

    always #10 aclk = ~aclk;

    // Automatic mode: the select pin is wired back from the error flag.
    always @(posedge aclk)
        if (tie_sel)
            clock_source_sel <= error_flag;

    task automatic conclude;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        done = 1'b0;
        n = 0;
        while (!done && n < 100)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                chk(32'(s_axi_bresp), 32'(er));
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        chk(32'(done), 32'h1);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic done;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        done = 1'b0;
        n = 0;
        while (!done && n < 100)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                chk(32'(s_axi_rresp), 32'(er));
                if (er == `RESP_OKAY)
                    chk(s_axi_rdata, ed);
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        chk(32'(done), 32'h1);
    endtask

    // Counts rising edges of the three clocks and source change pulses.
    task automatic count(input int len, output int s, output int b, output int f, output int c);
        logic ps, pb, pf;
        s = 0;
        b = 0;
        f = 0;
        c = 0;
        ps = system_clock_out;
        pb = bit_clock_out;
        pf = frame_clock_out;
        repeat (len)
        begin
            @(posedge aclk);
            s += (system_clock_out === 1'b1 && !ps);
            b += (bit_clock_out === 1'b1 && !pb);
            f += (frame_clock_out === 1'b1 && !pf);
            c += (clock_change_pulse === 1'b1);
            ps = system_clock_out;
            pb = bit_clock_out;
            pf = frame_clock_out;
        end
    endtask

    task automatic wait_err(input logic v, input int lim);
        int n;
        n = 0;
        while (error_flag !== v && n < lim)
        begin
            @(posedge aclk);
            n++;
        end
    endtask

    task automatic t_reset;
        repeat (10) @(posedge aclk);
        chk(32'({system_clock_out, bit_clock_out, frame_clock_out, block_start_flag,
            clock_change_pulse, channel_status_out, emphasis_flag, rate_code_out0,
            rate_code_out1, user_bit_out}), 32'h0);
        chk(32'(error_flag), 32'h1);
        chk(32'({osc_clock_in, osc_drive_out}), 32'h2);
    endtask

    task automatic t_regs;
        rd_chk(`REG_CTRL, `CTRL_RESET, `RESP_OKAY);
        wr_chk(`REG_CTRL, 32'h1, `RESP_OKAY);
        rd_chk(`REG_CTRL, 32'h1, `RESP_OKAY);
        wr_chk(`REG_CTRL, 32'h0, `RESP_OKAY);
        pll_ratio_sel <= 2'h2;
        rd_chk(`REG_RATIO, 32'h2, `RESP_OKAY);
        rd_chk(12'h010, 32'h0, `RESP_SLVERR);
        wr_chk(`REG_STATUS, 32'hff, `RESP_SLVERR);
    endtask

    task automatic t_lock;
        repeat (300) @(posedge aclk);
        chk(32'(error_flag), 32'h1);
        lock_on <= 1'b1;
        wait_err(1'b0, 100);
        chk(32'(error_flag), 32'h0);
        stream_on <= 1'b0;
        wait_err(1'b1, 2000);
        chk(32'(error_flag), 32'h1);
        stream_on <= 1'b1;
        wait_err(1'b0, 2000);
        chk(32'(error_flag), 32'h0);
    endtask

    task automatic t_ratio;
        int s, b, f, c, k, n;
        for (int r = 0; r < 4; r++)
        begin
            @(posedge aclk);
            pll_ratio_sel <= 2'(r);
            k = 2 * (r + 1);
            count(1100, s, b, f, c);
            count(4096, s, b, f, c);
            chk(32'(b * k <= s + k && s <= b * k + k), 32'h1);
            chk(32'(f * 64 <= b + 64 && b <= f * 64 + 64), 32'h1);
        end
        // At ratio code 3 the frame period is 1024 cycles: two block starts expected.
        n = 0;
        repeat (2048)
        begin
            @(posedge aclk);
            n += (block_start_flag === 1'b1);
        end
        chk(32'(n >= 1 && n <= 3), 32'h1);
    endtask

    task automatic t_select;
        int s, b, f, c;
        @(posedge aclk);
        clock_source_sel <= 1'b1;
        pll_run <= 1'b0;
        count(400, s, b, f, c);
        chk(32'(s >= 97 && s <= 101), 32'h1);
        pll_run <= 1'b1;
        osc_run <= 1'b0;
        count(400, s, b, f, c);
        chk(32'(s <= 1), 32'h1);
        chk(32'({osc_clock_in, osc_drive_out}), 32'h1);
        clock_source_sel <= 1'b0;
        count(400, s, b, f, c);
        chk(32'(s >= 197 && s <= 201 && c >= 1), 32'h1);
    endtask

    task automatic t_auto;
        int s, b, f, c;
        tie_sel <= 1'b1;
        count(400, s, b, f, c);
        chk(32'(s >= 195), 32'h1);
        stream_on <= 1'b0;
        wait_err(1'b1, 2000);
        count(400, s, b, f, c);
        chk(32'(s <= 1 && error_flag === 1'b1), 32'h1);
        stream_on <= 1'b1;
        wait_err(1'b0, 2000);
        count(400, s, b, f, c);
        chk(32'(s >= 195), 32'h1);
    endtask

    initial
    begin
        t_reset();
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_lock();
        t_ratio();
        t_select();
        t_auto();
        conclude();
    end

    initial
    begin
        #1500000;
        errors++;
        conclude();
    end
endmodule
